// >>> rre_pkg.sv
// Package: constants, register map and carrier types of the return and rotate core
package rre_pkg;
   // Datapath widths
   localparam int PC_W = 21;
   localparam int ST_W = 5;
   localparam int BANK_W = 4;
   localparam int FA_W = 12;
   // Status flag positions
   localparam int ST_C = 0;
   localparam int ST_Z = 2;
   localparam int ST_N = 4;
   // Interrupt enable positions
   localparam int IE_HIGH = 7;
   localparam int IE_LOW = 6;
   // Control and execution status positions
   localparam int CTRL_EXT = 0;
   localparam int CTRL_LOWLVL = 1;
   localparam int XS_BUSY = 0;
   localparam int XS_ILL = 1;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_INSTR = 8'h04;
   localparam logic [7:0] OFS_W = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_BANK = 8'h10;
   localparam logic [7:0] OFS_WSHAD = 8'h14;
   localparam logic [7:0] OFS_STSHAD = 8'h18;
   localparam logic [7:0] OFS_BKSHAD = 8'h1C;
   localparam logic [7:0] OFS_PC = 8'h20;
   localparam logic [7:0] OFS_INTEN = 8'h24;
   localparam logic [7:0] OFS_LATCH = 8'h28;
   localparam logic [7:0] OFS_FSR2 = 8'h2C;
   localparam logic [7:0] OFS_XSTAT = 8'h30;
   // Opcode patterns
   localparam logic [15:0] OPC_RET_MASK = 16'hFFFE;
   localparam logic [15:0] OPC_INT_RET = 16'h0010;
   localparam logic [15:0] OPC_RETURN = 16'h0012;
   localparam logic [7:0] OPC_LIT_RET_HI = 8'h0C;
   localparam logic [5:0] OPC_ROT_HI = 6'h0D;
   // Indexed literal offset and access bank split
   localparam logic [7:0] ACC_LIMIT = 8'h5F;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   // Quarter phases
   localparam logic [1:0] Q1_IDX = 2'h0;
   localparam logic [1:0] Q2_IDX = 2'h1;
   localparam logic [1:0] Q4_IDX = 2'h3;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [PC_W-1:0] RST_PC = 21'h000000;
   // Types
   typedef enum logic [1:0] {RRE_IDLE, RRE_CYC1, RRE_CYC2} rre_state_t;
   typedef enum logic [2:0] {K_NONE, K_INT_RET, K_RETURN, K_LIT_RET, K_ROT} rre_kind_t;
   typedef struct packed {
      rre_kind_t kind;
      logic s;
      logic d;
      logic a;
      logic [7:0] lit;
   } rre_dec_t;
   typedef struct packed {
      logic [7:0] result;
      logic carry;
      logic neg;
      logic zero;
   } rre_rot_t;
endpackage : rre_pkg

// >>> rre_qphase.sv
// Quarter phase divider of the instruction cycle
`timescale 1ns/1ps
module rre_qphase (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Phase outputs
   output logic [1:0] q_idx,
   output logic q_last
);
   import rre_pkg::*;

   // Free running phase counter, last phase flagged
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_idx <= Q1_IDX;
      end else begin
         q_idx <= q_idx + 2'h1;
      end
   end

   assign q_last = (q_idx == Q4_IDX);
endmodule : rre_qphase

// >>> rre_rotate.sv
// Rotate through carry datapath and file address selection
`timescale 1ns/1ps
module rre_rotate (
   // Operand side
   input wire logic [7:0] operand,
   input wire logic carry_in,
   // Addressing side
   input wire logic [7:0] f_addr,
   input wire logic a_bit,
   input wire logic ext_en,
   input wire logic [rre_pkg::BANK_W-1:0] bank_sel,
   input wire logic [rre_pkg::FA_W-1:0] fsr2,
   // Results
   output rre_pkg::rre_rot_t rot,
   output logic [rre_pkg::FA_W-1:0] eff_addr
);
   import rre_pkg::*;

   // Shift up, old carry into bit 0, bit 7 out to carry
   always_comb begin
      rot.result = {operand[6:0], carry_in};
      rot.carry = operand[7];
      rot.neg = operand[6];
      rot.zero = ({operand[6:0], carry_in} == 8'h00);
   end

   // Banked, indexed or access bank address
   always_comb begin
      if (a_bit) begin
         eff_addr = {bank_sel, f_addr};
      end else if (ext_en && (f_addr <= ACC_LIMIT)) begin
         eff_addr = fsr2 + {4'h0, f_addr};
      end else if (f_addr <= ACC_LIMIT) begin
         eff_addr = {4'h0, f_addr};
      end else begin
         eff_addr = {ACC_HI_BANK, f_addr};
      end
   end
endmodule : rre_rotate

// >>> rre_core.sv
// Return and rotate execution core with AHB-Lite register slave
`timescale 1ns/1ps
//
// Contract
// - interrupt return pops stack into PC, two cycles
// - interrupt return sets high or low global enable
// - shadow flag set restores W, status, bank select
// - returns never touch the PC latch registers
// - literal return loads W, pops PC, two cycles
// - literal return acts in fourth phase, cycle one
// - subroutine return pops stack into PC, two cycles
// - subroutine return restores shadows when flag set
// - rotate left through carry, update C N Z
// - destination bit picks W or file register
// - bank bit picks access bank or banked register
// - extended set indexes literal offset below 60h
module rre_core (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Return stack
   input wire logic [rre_pkg::PC_W-1:0] stack_top_entry,
   output logic stack_pop,
   output logic refetch,
   // File register port
   output logic [rre_pkg::FA_W-1:0] file_addr,
   output logic [7:0] file_wdata,
   output logic file_we,
   input wire logic [7:0] file_rdata
);
   import rre_pkg::*;

   logic [1:0] q_idx;
   logic q_last;
   rre_rot_t rot;
   logic [FA_W-1:0] eff_addr;
   logic [7:0] addr_reg;
   logic wr_pend_reg, rd_pend_reg;
   logic [31:0] rd_val;
   logic [1:0] ctrl_reg;
   logic [15:0] instr_reg;
   logic pend_reg, ill_reg;
   rre_state_t state_reg;
   rre_dec_t dec_reg, dec_next;
   logic [7:0] w_reg, wshad_reg, operand_reg, inten_reg, pch_latch_reg;
   logic [ST_W-1:0] status_reg, stshad_reg;
   logic [BANK_W-1:0] bank_reg, bkshad_reg;
   logic [4:0] pcu_latch_reg;
   logic [PC_W-1:0] pc_reg;
   logic [FA_W-1:0] fsr2_reg;
   logic busy, act, is_ret, restore, ill_set;
   logic bus_wr_instr;

   rre_qphase u_qphase (
      .hclk(hclk),
      .hresetn(hresetn),
      .q_idx(q_idx),
      .q_last(q_last)
   );

   rre_rotate u_rotate (
      .operand(operand_reg),
      .carry_in(status_reg[ST_C]),
      .f_addr(dec_reg.lit),
      .a_bit(dec_reg.a),
      .ext_en(ctrl_reg[CTRL_EXT]),
      .bank_sel(bank_reg),
      .fsr2(fsr2_reg),
      .rot(rot),
      .eff_addr(eff_addr)
   );

   // Bus address phase capture, one wait state on reads
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_reg <= RST_BYTE;
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (hsel && htrans[1] && hready) begin
            addr_reg <= haddr[7:0];
            wr_pend_reg <= hwrite;
            rd_pend_reg <= !hwrite;
            hreadyout <= hwrite;
         end else begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            hreadyout <= 1'b1;
         end
      end
   end

   // Read mux, unmapped reads as zero
   always_comb begin
      case (addr_reg)
         OFS_CTRL: rd_val = {30'h0, ctrl_reg};
         OFS_INSTR: rd_val = {16'h0, instr_reg};
         OFS_W: rd_val = {24'h0, w_reg};
         OFS_STATUS: rd_val = {27'h0, status_reg};
         OFS_BANK: rd_val = {28'h0, bank_reg};
         OFS_WSHAD: rd_val = {24'h0, wshad_reg};
         OFS_STSHAD: rd_val = {27'h0, stshad_reg};
         OFS_BKSHAD: rd_val = {28'h0, bkshad_reg};
         OFS_PC: rd_val = {11'h0, pc_reg};
         OFS_INTEN: rd_val = {24'h0, inten_reg};
         OFS_LATCH: rd_val = {19'h0, pcu_latch_reg, pch_latch_reg};
         OFS_FSR2: rd_val = {20'h0, fsr2_reg};
         OFS_XSTAT: rd_val = {30'h0, ill_reg, busy};
         default: rd_val = 32'h0;
      endcase
   end

   // Read data, loaded in the wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (rd_pend_reg) begin
         hrdata <= rd_val;
      end
   end

   // Opcode decode
   always_comb begin
      dec_next = '{kind: K_NONE, s: instr_reg[0], d: instr_reg[9], a: instr_reg[8],
                   lit: instr_reg[7:0]};
      if ((instr_reg & OPC_RET_MASK) == OPC_INT_RET) begin
         dec_next.kind = K_INT_RET;
      end else if ((instr_reg & OPC_RET_MASK) == OPC_RETURN) begin
         dec_next.kind = K_RETURN;
      end else if (instr_reg[15:8] == OPC_LIT_RET_HI) begin
         dec_next.kind = K_LIT_RET;
      end else if (instr_reg[15:10] == OPC_ROT_HI) begin
         dec_next.kind = K_ROT;
      end
   end

   assign busy = pend_reg || (state_reg != RRE_IDLE);
   assign bus_wr_instr = wr_pend_reg && (addr_reg == OFS_INSTR) && !busy;
   assign act = (state_reg == RRE_CYC1) && (q_idx == Q4_IDX);
   assign is_ret = (dec_reg.kind == K_INT_RET) || (dec_reg.kind == K_RETURN)
                   || (dec_reg.kind == K_LIT_RET);
   assign restore = act && dec_reg.s
                    && ((dec_reg.kind == K_INT_RET) || (dec_reg.kind == K_RETURN));
   assign ill_set = act && (dec_reg.kind == K_NONE);

   // Instruction word and start request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr_reg <= 16'h0000;
         pend_reg <= 1'b0;
      end else if (bus_wr_instr) begin
         instr_reg <= hwdata[15:0];
         pend_reg <= 1'b1;
      end else if (pend_reg && q_last) begin
         pend_reg <= 1'b0;
      end
   end

   // Cycle sequencer: returns take two cycles, rotate one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= RRE_IDLE;
         dec_reg <= '0;
      end else begin
         case (state_reg)
            RRE_IDLE: begin
               if (pend_reg && q_last) begin
                  state_reg <= RRE_CYC1;
                  dec_reg <= dec_next;
               end
            end
            RRE_CYC1: begin
               if (q_last) begin
                  state_reg <= is_ret ? RRE_CYC2 : RRE_IDLE;
               end
            end
            RRE_CYC2: begin
               if (q_last) begin
                  state_reg <= RRE_IDLE;
               end
            end
            default: state_reg <= RRE_IDLE;
         endcase
      end
   end

   // File access: address in Q1, read in Q2, write strobe one clock after Q4
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         file_addr <= 12'h000;
         operand_reg <= RST_BYTE;
         file_wdata <= RST_BYTE;
         file_we <= 1'b0;
      end else begin
         if ((state_reg == RRE_CYC1) && (q_idx == Q1_IDX)) begin
            file_addr <= eff_addr;
         end
         if ((state_reg == RRE_CYC1) && (q_idx == Q2_IDX)) begin
            operand_reg <= file_rdata;
         end
         file_we <= act && (dec_reg.kind == K_ROT) && dec_reg.d;
         file_wdata <= rot.result;
      end
   end

   // Stack pop and prefetch discard pulses
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stack_pop <= 1'b0;
         refetch <= 1'b0;
      end else begin
         stack_pop <= act && is_ret;
         refetch <= (state_reg == RRE_CYC1) && q_last && is_ret;
      end
   end

   // Program counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_reg <= RST_PC;
      end else if (act && is_ret) begin
         pc_reg <= stack_top_entry;
      end else if (wr_pend_reg && (addr_reg == OFS_PC)) begin
         pc_reg <= hwdata[PC_W-1:0];
      end
   end

   // Working register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         w_reg <= RST_BYTE;
      end else if (act && (dec_reg.kind == K_LIT_RET)) begin
         w_reg <= dec_reg.lit;
      end else if (restore) begin
         w_reg <= wshad_reg;
      end else if (act && (dec_reg.kind == K_ROT) && !dec_reg.d) begin
         w_reg <= rot.result;
      end else if (wr_pend_reg && (addr_reg == OFS_W)) begin
         w_reg <= hwdata[7:0];
      end
   end

   // Status flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= 5'h00;
      end else if (restore) begin
         status_reg <= stshad_reg;
      end else if (act && (dec_reg.kind == K_ROT)) begin
         status_reg[ST_C] <= rot.carry;
         status_reg[ST_N] <= rot.neg;
         status_reg[ST_Z] <= rot.zero;
      end else if (wr_pend_reg && (addr_reg == OFS_STATUS)) begin
         status_reg <= hwdata[ST_W-1:0];
      end
   end

   // Bank select
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_reg <= 4'h0;
      end else if (restore) begin
         bank_reg <= bkshad_reg;
      end else if (wr_pend_reg && (addr_reg == OFS_BANK)) begin
         bank_reg <= hwdata[BANK_W-1:0];
      end
   end

   // Global interrupt enables, re-armed by interrupt return
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         inten_reg <= RST_BYTE;
      end else if (act && (dec_reg.kind == K_INT_RET)) begin
         if (ctrl_reg[CTRL_LOWLVL]) begin
            inten_reg[IE_LOW] <= 1'b1;
         end else begin
            inten_reg[IE_HIGH] <= 1'b1;
         end
      end else if (wr_pend_reg && (addr_reg == OFS_INTEN)) begin
         inten_reg <= hwdata[7:0];
      end
   end

   // Software-only registers; the PC latches stay out of every return
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= 2'h0;
         wshad_reg <= RST_BYTE;
         stshad_reg <= 5'h00;
         bkshad_reg <= 4'h0;
         pcu_latch_reg <= 5'h00;
         pch_latch_reg <= RST_BYTE;
         fsr2_reg <= 12'h000;
      end else if (wr_pend_reg) begin
         case (addr_reg)
            OFS_CTRL: ctrl_reg <= hwdata[1:0];
            OFS_WSHAD: wshad_reg <= hwdata[7:0];
            OFS_STSHAD: stshad_reg <= hwdata[ST_W-1:0];
            OFS_BKSHAD: bkshad_reg <= hwdata[BANK_W-1:0];
            OFS_LATCH: {pcu_latch_reg, pch_latch_reg} <= hwdata[12:0];
            OFS_FSR2: fsr2_reg <= hwdata[FA_W-1:0];
            default: ;
         endcase
      end
   end

   // Unknown opcode flag, write one to clear, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ill_reg <= 1'b0;
      end else if (ill_set) begin
         ill_reg <= 1'b1;
      end else if (wr_pend_reg && (addr_reg == OFS_XSTAT) && hwdata[XS_ILL]) begin
         ill_reg <= 1'b0;
      end
   end

   // Checks
   sequence s_ret_act;
      act && is_ret;
   endsequence
   sequence s_ret_tail;
      (state_reg == RRE_CYC2) [*4] ##1 (state_reg == RRE_IDLE);
   endsequence

   a_ret_pop_pc: assert property (@(posedge hclk) disable iff (!hresetn)
      s_ret_act |=> stack_pop && (pc_reg == $past(stack_top_entry)))
      else $error("return did not pop stack into PC");
   a_gie_rearm: assert property (@(posedge hclk) disable iff (!hresetn)
      act && (dec_reg.kind == K_INT_RET) |=>
      (ctrl_reg[CTRL_LOWLVL] ? inten_reg[IE_LOW] : inten_reg[IE_HIGH]))
      else $error("interrupt return left global enable clear");
   a_shadow_restore: assert property (@(posedge hclk) disable iff (!hresetn)
      restore |=> (w_reg == $past(wshad_reg)) && (status_reg == $past(stshad_reg))
      && (bank_reg == $past(bkshad_reg)))
      else $error("shadow restore mismatch");
   a_no_restore: assert property (@(posedge hclk) disable iff (!hresetn)
      act && !dec_reg.s && (dec_reg.kind == K_RETURN) && !wr_pend_reg |=>
      $stable(w_reg) && $stable(status_reg) && $stable(bank_reg))
      else $error("return without shadow flag changed registers");
   a_latch_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      s_ret_act |=> $stable(pcu_latch_reg) && $stable(pch_latch_reg))
      else $error("PC latch changed by return");
   a_lit_to_w: assert property (@(posedge hclk) disable iff (!hresetn)
      act && (dec_reg.kind == K_LIT_RET) |=> (w_reg == $past(dec_reg.lit))
      && $stable(status_reg))
      else $error("literal return did not load W");
   a_ret_two_cyc: assert property (@(posedge hclk) disable iff (!hresetn)
      s_ret_act |=> s_ret_tail)
      else $error("return second cycle wrong length");
   a_rot_flags: assert property (@(posedge hclk) disable iff (!hresetn)
      act && (dec_reg.kind == K_ROT) |=>
      (status_reg[ST_C] == $past(operand_reg[7]))
      && (status_reg[ST_Z] == ($past(rot.result) == 8'h00)))
      else $error("rotate flags wrong");
   a_rot_dest: assert property (@(posedge hclk) disable iff (!hresetn)
      act && (dec_reg.kind == K_ROT) |=> (file_we == $past(dec_reg.d))
      && (!file_we || (file_wdata == {$past(operand_reg[6:0]), $past(status_reg[ST_C])})))
      else $error("rotate destination wrong");
   a_bank_addr: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == RRE_CYC1) && (q_idx == Q1_IDX) && dec_reg.a |=>
      (file_addr == {$past(bank_reg), $past(dec_reg.lit)}))
      else $error("banked address wrong");
endmodule : rre_core

// >>> tb.sv
// Self-checking testbench of the return and rotate core
`timescale 1ns/1ps
module tb;
   import rre_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [PC_W-1:0] stack_top = '0;
   logic stack_pop;
   logic refetch;
   logic [FA_W-1:0] file_addr;
   logic [7:0] file_wdata;
   logic file_we;
   logic [7:0] file_rdata = 8'h00;
   int fails = 0;
   int n_tests = 0;
   int n_pop = 0;
   int n_ref = 0;
   int n_we = 0;
   int cyc = 0;
   logic [FA_W-1:0] we_addr;
   logic [7:0] we_data;
   // Clock of 25 ns
   always #12.5 hclk = ~hclk;
   rre_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stack_top_entry(stack_top),
      .stack_pop(stack_pop), .refetch(refetch), .file_addr(file_addr),
      .file_wdata(file_wdata), .file_we(file_we), .file_rdata(file_rdata));
   // Pulse counters, file write capture and hang limit
   always @(posedge hclk) begin
      cyc++;
      if (stack_pop === 1'b1) n_pop++;
      if (refetch === 1'b1) n_ref++;
      if (file_we === 1'b1) begin
         n_we++;
         we_addr = file_addr;
         we_data = file_wdata;
      end
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // Single word write: address phase, then data phase
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask : wr
   // Single word read, data taken at the edge that sees ready
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
      chk({31'h0, hresp}, 32'h0, "response not OKAY");
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp, m);
   endtask : rchk
   // Launch one opcode and wait for busy to drop
   task automatic exec(input logic [15:0] op);
      logic [31:0] d;
      wr(OFS_INSTR, {16'h0000, op});
      repeat (14) @(posedge hclk);
      d = 32'h1;
      while (d[XS_BUSY] !== 1'b0) rd(OFS_XSTAT, d);
   endtask : exec
   // Reset values and unmapped place
   task automatic t_reset();
      rchk(OFS_W, 32'h0, "W reset");
      rchk(OFS_PC, 32'h0, "PC reset");
      rchk(OFS_INTEN, 32'h0, "INTEN reset");
      rchk(OFS_XSTAT, 32'h0, "XSTAT reset");
      wr(8'h40, 32'hFFFFFFFF);
      rchk(8'h40, 32'h0, "unmapped read");
   endtask : t_reset
   // One return opcode with shadows, latches and enables preset
   task automatic ret_case(input logic [15:0] op, input logic [PC_W-1:0] t,
         input logic [1:0] ctrl);
      logic s;
      logic lit;
      logic fie;
      int p0;
      int r0;
      s = op[0];
      lit = (op[15:8] == OPC_LIT_RET_HI);
      fie = ((op & OPC_RET_MASK) == OPC_INT_RET);
      wr(OFS_CTRL, {30'h0, ctrl});
      wr(OFS_W, 32'h11);
      wr(OFS_STATUS, 32'h05);
      wr(OFS_BANK, 32'h2);
      wr(OFS_WSHAD, 32'hA5);
      wr(OFS_STSHAD, 32'h1A);
      wr(OFS_BKSHAD, 32'h9);
      wr(OFS_LATCH, 32'h1ABC);
      wr(OFS_INTEN, 32'h0);
      wr(OFS_PC, 32'h0);
      stack_top <= t;
      p0 = n_pop;
      r0 = n_ref;
      exec(op);
      rchk(OFS_PC, {11'h0, t}, "PC from stack top");
      chk(n_pop - p0, 1, "pop count");
      chk(n_ref - r0, 1, "refetch count");
      rchk(OFS_LATCH, 32'h1ABC, "latches changed");
      rchk(OFS_W, lit ? {24'h0, op[7:0]} : (s ? 32'hA5 : 32'h11), "W");
      rchk(OFS_STATUS, (s && !lit) ? 32'h1A : 32'h05, "STATUS");
      rchk(OFS_BANK, (s && !lit) ? 32'h9 : 32'h2, "bank select");
      rchk(OFS_INTEN, fie ? (ctrl[1] ? 32'h40 : 32'h80) : 32'h0, "enables");
   endtask : ret_case
   // One rotate with operand, carry and addressing choices
   task automatic rot_case(input logic [7:0] v, input logic c, input logic d, input logic a,
         input logic ext, input logic [7:0] f, input logic [3:0] bank, input logic [11:0] fsr2);
      logic [7:0] res;
      logic [11:0] ea;
      int w0;
      res = {v[6:0], c};
      if (a) ea = {bank, f};
      else if (ext && f <= ACC_LIMIT) ea = fsr2 + {4'h0, f};
      else if (f <= ACC_LIMIT) ea = {4'h0, f};
      else ea = {4'hF, f};
      wr(OFS_CTRL, {31'h0, ext});
      wr(OFS_BANK, {28'h0, bank});
      wr(OFS_FSR2, {20'h0, fsr2});
      wr(OFS_STATUS, {31'h0, c});
      wr(OFS_W, 32'h77);
      file_rdata <= v;
      w0 = n_we;
      exec({OPC_ROT_HI, d, a, f});
      rchk(OFS_STATUS, {27'h0, res[7], 1'b0, res == 8'h00, 1'b0, v[7]}, "flags");
      rchk(OFS_W, d ? 32'h77 : {24'h0, res}, "W dest");
      chk(n_we - w0, {31'h0, d}, "file write count");
      if (d) begin
         chk({24'h0, we_data}, {24'h0, res}, "file data");
         chk({20'h0, we_addr}, {20'h0, ea}, "file address");
      end
   endtask : rot_case
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      ret_case(16'h0011, 21'h0ABCDE, 2'h0);
      ret_case(16'h0010, 21'h1FFFFE, 2'h2);
      ret_case(16'h0013, 21'h012344, 2'h0);
      ret_case(16'h0012, 21'h000002, 2'h0);
      ret_case(16'h0C7E, 21'h100000, 2'h0);
      ret_case(16'h0C00, 21'h0F0F0E, 2'h2);
      rot_case(8'hE6, 1'b0, 1'b0, 1'b0, 1'b0, 8'h10, 4'h0, 12'h000);
      rot_case(8'h80, 1'b0, 1'b1, 1'b0, 1'b0, 8'h5F, 4'h0, 12'h000);
      rot_case(8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 8'h60, 4'h0, 12'h000);
      rot_case(8'h55, 1'b0, 1'b1, 1'b1, 1'b0, 8'h20, 4'h3, 12'h000);
      rot_case(8'h40, 1'b1, 1'b1, 1'b0, 1'b1, 8'h5F, 4'h0, 12'h100);
      rot_case(8'h40, 1'b0, 1'b1, 1'b0, 1'b1, 8'h60, 4'h0, 12'h100);
      rot_case(8'hFF, 1'b1, 1'b1, 1'b1, 1'b1, 8'h10, 4'h2, 12'h100);
      finish_test();
   end
endmodule : tb
